// ==== rtl/cbc_crc_unit.sv ====
// Notes on behaviour
// RULE_01: Result updates one clock after each byte written to the byte input register.
// RULE_02: The written byte is the next CRC operand; register is write-only, 8 bits.
// RULE_03: Reset clears the result to zero; a reset command may set all ones.
// RULE_04: Result registers accept software writes only while the source is disabled.
// RULE_05: With flash controller source, result reads return zero until busy clears.
// RULE_06: Wide polynomial and busy clear: result reads bit-reversed then inverted.
// RULE_07: Narrow polynomial, or busy set with register input source: result reads the raw remainder.
// RULE_08: Result bytes 0 to 3 sit at offsets 4 to 7 ascending.
// RULE_09: Narrow CRC uses 0x1021; wide select bit chooses 0x04C11DB7.
// RULE_10: Reset code 10 clears, 11 sets ones, two clocks later; field reads zero.
// RULE_11: Source field picks disabled, register input or flash; locked while busy.
// RULE_12: Busy is one while a source is in use; cleared by software or flash.
// RULE_13: In narrow mode the upper two result bytes read as zero.
`timescale 1ns/1ps
`default_nettype none

module cbc_crc_unit
  import cbc_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  input  wire logic [CBC_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  input  wire logic [7:0]            nvm_byte_in,
  input  wire logic                  nvm_byte_valid_in,
  input  wire logic                  nvm_done_in,
  output logic                       busy_out,
  output logic                       zero_out
);

  // ----------------------------------------------------------------
  // One byte step of the CRC engine.
  // ----------------------------------------------------------------
  function automatic logic [31:0] cbc_crc_step(input logic [31:0] crc,
                                               input logic [7:0]  din,
                                               input logic        wide);
    logic [31:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (wide) begin
        fb = c[31] ^ din[i];
        c  = {c[30:0], 1'b0} ^ (fb ? POLY_32 : 32'h00000000);
      end else begin
        fb = c[15] ^ din[7-i];
        c  = {16'h0000, c[14:0], 1'b0} ^ (fb ? {16'h0000, POLY_16} : 32'h00000000);
      end
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  logic [31:0] crc_q;
  logic [31:0] crc_d;
  logic [3:0]  src_q;
  logic [3:0]  src_d;
  logic        wide_q;
  logic        wide_d;
  logic        busy_q;
  logic        busy_d;
  logic        zero_q;
  logic        zero_d;
  logic        rst_pend_q;
  logic        rst_pend_d;
  logic        rst_fill_q;
  logic        rst_fill_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_control = reg_wr_in && (reg_addr_in == OFF_CONTROL);
  wire wr_flags   = reg_wr_in && (reg_addr_in == OFF_FLAGS);
  wire wr_byte_in = reg_wr_in && (reg_addr_in == OFF_BYTE_IN);
  wire wr_result  = reg_wr_in && reg_addr_in[2];

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire       src_is_reg   = (src_q == SRC_REG_IN);
  wire       src_is_nvm   = (src_q == SRC_NVM);
  wire       src_is_off   = (src_q == SRC_DISABLED);
  wire       rst_cmd      = wr_control && reg_wdata_in[CTL_RST_HI_BIT]; // see RULE_10
  wire       rst_cmd_fill = reg_wdata_in[CTL_RST_LO_BIT];
  wire       ctl_unlocked = wr_control && !busy_q; // see RULE_11
  wire [3:0] src_field    = reg_wdata_in[CTL_SRC_MSB:0];
  wire       src_legal    = (src_field == SRC_REG_IN) || (src_field == SRC_NVM);
  wire [3:0] src_new      = src_legal ? src_field : SRC_DISABLED; // see RULE_11
  wire       wide_eff     = wide_q || src_is_nvm;

  // ----------------------------------------------------------------
  // Byte feed and completion
  // ----------------------------------------------------------------
  wire        reg_feed   = wr_byte_in && busy_q && src_is_reg; // see RULE_02
  wire        nvm_feed   = nvm_byte_valid_in && busy_q && src_is_nvm;
  wire        feed_en    = reg_feed || nvm_feed;
  wire [7:0]  feed_byte  = reg_feed ? reg_wdata_in : nvm_byte_in;
  wire [31:0] crc_stepped = cbc_crc_step(crc_q, feed_byte, wide_eff); // see RULE_09
  wire        reg_done   = wr_flags && reg_wdata_in[FLG_BUSY_BIT] && busy_q && src_is_reg;
  wire        nvm_done   = nvm_done_in && busy_q && src_is_nvm;
  wire        gen_done   = reg_done || nvm_done; // see RULE_12

  // ----------------------------------------------------------------
  // Result views
  // ----------------------------------------------------------------
  logic [31:0] crc_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_rev
      assign crc_rev[gi] = crc_q[31-gi]; // see RULE_06
    end
  endgenerate

  wire [31:0] raw_view   = wide_eff ? crc_q : {16'h0000, crc_q[15:0]}; // see RULE_13
  wire [31:0] final_view = wide_eff ? ~crc_rev : raw_view; // see RULE_06
  wire [31:0] read_view  = (src_is_nvm && busy_q) ? RESULT_RST : // see RULE_05
                           (busy_q ? raw_view : final_view); // see RULE_07

  // ----------------------------------------------------------------
  // Result register next value
  // ----------------------------------------------------------------
  always_comb begin
    crc_d = crc_q;
    if (rst_pend_q) begin
      crc_d = rst_fill_q ? RESULT_ONES : RESULT_RST; // see RULE_03
    end else if (wr_result && src_is_off) begin
      unique case (reg_addr_in) // see RULE_04
        OFF_RESULT0: crc_d[7:0]   = reg_wdata_in;
        OFF_RESULT1: crc_d[15:8]  = reg_wdata_in;
        OFF_RESULT2: crc_d[23:16] = reg_wdata_in;
        OFF_RESULT3: crc_d[31:24] = reg_wdata_in;
        default:     crc_d        = crc_q;
      endcase
    end else if (feed_en) begin
      crc_d = crc_stepped; // see RULE_01
    end
  end

  // ----------------------------------------------------------------
  // Control and flag next values
  // ----------------------------------------------------------------
  always_comb begin
    rst_pend_d = rst_cmd; // see RULE_10
    rst_fill_d = rst_cmd ? rst_cmd_fill : rst_fill_q;
    src_d      = ctl_unlocked ? src_new : src_q;
    wide_d     = ctl_unlocked ? reg_wdata_in[CTL_WIDE_BIT] : wide_q;
    busy_d     = busy_q;
    if (gen_done || rst_pend_q) begin
      busy_d = 1'b0; // see RULE_12
    end
    if (ctl_unlocked) begin
      busy_d = (src_new != SRC_DISABLED); // see RULE_12
    end
    zero_d = zero_q;
    if (ctl_unlocked) begin
      zero_d = 1'b0;
    end
    if (gen_done) begin
      zero_d = (final_view == RESULT_RST);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] rd_control = {2'b00, wide_q, 1'b0, src_q} & 8'h2F; // see RULE_10
  wire [7:0] rd_flags   = {6'h00, zero_q, busy_q};
  wire [7:0] rd_result  = read_view[{reg_addr_in[1:0], 3'b000} +: 8]; // see RULE_08
  wire [7:0] rd_word    = (reg_addr_in == OFF_CONTROL) ? rd_control :
                          (reg_addr_in == OFF_FLAGS)   ? rd_flags   :
                          reg_addr_in[2]               ? rd_result  : BYTE_ZERO;

  always_comb begin
    rdata_d = reg_rd_in ? rd_word : BYTE_ZERO;
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      crc_q      <= RESULT_RST; // see RULE_03
      src_q      <= SRC_DISABLED;
      wide_q     <= 1'b0;
      busy_q     <= 1'b0;
      zero_q     <= 1'b0;
      rst_pend_q <= 1'b0;
      rst_fill_q <= 1'b0;
      rdata_q    <= BYTE_ZERO;
    end else begin
      crc_q      <= crc_d;
      src_q      <= src_d;
      wide_q     <= wide_d;
      busy_q     <= busy_d;
      zero_q     <= zero_d;
      rst_pend_q <= rst_pend_d;
      rst_fill_q <= rst_fill_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign busy_out      = busy_q;
  assign zero_out      = zero_q;

endmodule

`default_nettype wire

// ==== rtl/cbc_pkg.sv ====
package cbc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int unsigned CBC_ADDR_W = 3;
  localparam logic [2:0] OFF_CONTROL  = 3'h0;
  localparam logic [2:0] OFF_FLAGS    = 3'h1;
  localparam logic [2:0] OFF_BYTE_IN  = 3'h3;
  localparam logic [2:0] OFF_RESULT0  = 3'h4;
  localparam logic [2:0] OFF_RESULT1  = 3'h5;
  localparam logic [2:0] OFF_RESULT2  = 3'h6;
  localparam logic [2:0] OFF_RESULT3  = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_RST_HI_BIT = 7;
  localparam int unsigned CTL_RST_LO_BIT = 6;
  localparam int unsigned CTL_WIDE_BIT   = 5;
  localparam int unsigned CTL_SRC_MSB    = 3;
  localparam int unsigned FLG_ZERO_BIT   = 1;
  localparam int unsigned FLG_BUSY_BIT   = 0;

  // ----------------------------------------------------------------
  // Source codes and polynomials
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_DISABLED = 4'h0;
  localparam logic [3:0] SRC_REG_IN   = 4'h1;
  localparam logic [3:0] SRC_NVM      = 4'h2;
  localparam logic [15:0] POLY_16     = 16'h1021;
  localparam logic [31:0] POLY_32     = 32'h04C11DB7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESULT_RST  = 32'h00000000;
  localparam logic [31:0] RESULT_ONES = 32'hFFFFFFFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

endpackage

// ==== bench/cbc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbc_assertions
  import cbc_pkg::*;
(
  input wire logic                  clk_sys_in,
  input wire logic                  rst_in,
  input wire logic [CBC_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0]            reg_wdata_in,
  input wire logic                  reg_wr_in,
  input wire logic                  reg_rd_in,
  input wire logic [7:0]            reg_rdata_out,
  input wire logic [7:0]            nvm_byte_in,
  input wire logic                  nvm_byte_valid_in,
  input wire logic                  nvm_done_in,
  input wire logic                  busy_out,
  input wire logic                  zero_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  wire ctl_wr;
  assign ctl_wr = reg_wr_in && reg_addr_in == OFF_CONTROL;
  sequence s_rst_cmd;
    ctl_wr && reg_wdata_in[CTL_RST_HI_BIT] ##1 !ctl_wr;
  endsequence
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not idle");
  a_rst_field_rd: assert property (reg_rd_in && reg_addr_in == OFF_CONTROL |=> reg_rdata_out[7:6] == 2'b00)
    else $error("reset field read not zero");
  a_byte_in_rd: assert property (reg_rd_in && reg_addr_in == OFF_BYTE_IN |=> reg_rdata_out == 8'h00)
    else $error("byte input readable");
  a_busy_start: assert property (ctl_wr && !busy_out && reg_wdata_in[3:0] == SRC_REG_IN |=> busy_out)
    else $error("busy not set");
  a_reset_kill: assert property (s_rst_cmd |=> !busy_out)
    else $error("busy survived reset command");
  a_zero_clear: assert property (ctl_wr && !busy_out |=> !zero_out)
    else $error("zero not cleared");
  a_busy_source: assert property ($rose(busy_out) |-> $past(ctl_wr))
    else $error("busy rose without selection");
  a_busy_hold: assert property (busy_out && !reg_wr_in && !$past(reg_wr_in) && !nvm_done_in |=> busy_out)
    else $error("busy dropped without cause");
  a_zero_on_end: assert property ($rose(zero_out) |-> $fell(busy_out))
    else $error("zero set outside completion");
endmodule
bind cbc_crc_unit cbc_assertions u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .nvm_byte_in(nvm_byte_in),
  .nvm_byte_valid_in(nvm_byte_valid_in), .nvm_done_in(nvm_done_in),
  .busy_out(busy_out), .zero_out(zero_out));
`default_nettype wire

// ==== bench/cbc_nvm_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cbc_nvm_model (
  input  wire logic  clk_sys_in,
  input  wire logic  rst_in,
  input  wire logic  start_in,
  input  wire logic  slow_in,
  output var logic [7:0] byte_out = 8'h00,
  output var logic   valid_out = 1'b0,
  output var logic   done_out = 1'b0
);
  logic [3:0] idx_q = 4'h0;
  logic       run_q = 1'b0;
  logic       gap_q = 1'b0;
  // Streams the bytes 0x31 to 0x39, then signals completion.
  always @(posedge clk_sys_in) begin
    valid_out <= 1'b0;
    done_out <= 1'b0;
    byte_out <= ~byte_out;
    if (rst_in) begin
      run_q <= 1'b0;
    end else if (start_in) begin
      run_q <= 1'b1;
      idx_q <= 4'h0;
      gap_q <= 1'b0;
    end else if (run_q) begin
      gap_q <= slow_in & !gap_q;
      if (!gap_q && idx_q == 4'h9) begin
        done_out <= 1'b1;
        run_q <= 1'b0;
      end else if (!gap_q) begin
        valid_out <= 1'b1;
        byte_out <= 8'h31 + {4'h0, idx_q};
        idx_q <= idx_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import cbc_pkg::*;
;
  logic       clk_sys_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic       start = 1'b0, slow = 1'b0, nvm_valid, nvm_done, busy_out, zero_out;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, nvm_byte;
  int         fails = 0, checks_done = 0, cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  cbc_crc_unit DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .nvm_byte_in(nvm_byte), .nvm_byte_valid_in(nvm_valid),
    .nvm_done_in(nvm_done), .busy_out(busy_out), .zero_out(zero_out));
  cbc_nvm_model u_nvm (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start),
    .slow_in(slow), .byte_out(nvm_byte), .valid_out(nvm_valid), .done_out(nvm_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    #1;
    chk({24'h0, reg_rdata_out}, {24'h0, e});
  endtask
  task automatic rd32(input logic [31:0] e);
    for (int i = 0; i < 4; i++)
      rd(OFF_RESULT0 + 3'(i), e[8*i +: 8]);
  endtask
  task automatic feed(input logic [7:0] first, input int n);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= OFF_BYTE_IN;
    for (int i = 0; i < n; i++) begin
      reg_wdata_in <= first + 8'(i);
      @(posedge clk_sys_in);
    end
    reg_wr_in <= 1'b0;
  endtask
  task automatic t_narrow;
    for (int i = 2; i < 8; i++)
      rd(3'(i), 8'h00);
    acc(1'b1, OFF_RESULT0, 8'h5A);
    acc(1'b1, OFF_RESULT2, 8'h77);
    rd(OFF_RESULT0, 8'h5A);
    rd(OFF_RESULT2, 8'h00);
    acc(1'b1, OFF_CONTROL, 8'h80);
    rd(OFF_RESULT0, 8'h00);
    acc(1'b1, OFF_CONTROL, {4'h0, SRC_REG_IN});
    acc(1'b1, OFF_RESULT0, 8'h5A);
    acc(1'b1, OFF_CONTROL, 8'h00);
    feed(8'h31, 9);
    rd32(32'h000031C3);
    acc(1'b1, OFF_BYTE_IN, 8'h31);
    acc(1'b1, OFF_BYTE_IN, 8'hC3);
    acc(1'b1, OFF_FLAGS, 8'h01);
    #1;
    chk({busy_out, zero_out}, 2'b01);
    $display("test narrow done");
  endtask
  task automatic t_wide;
    logic [31:0] r;
    r = {<<{32'hCBF43926}};
    acc(1'b1, OFF_CONTROL, 8'hC0);
    rd32(32'h0000FFFF);
    acc(1'b1, OFF_CONTROL, 8'h21);
    feed(8'h31, 9);
    rd32(~r);
    acc(1'b1, OFF_FLAGS, 8'h01);
    rd32(32'hCBF43926);
    rd(OFF_CONTROL, 8'h21);
    $display("test wide done");
  endtask
  task automatic t_flash(input logic s);
    acc(1'b1, OFF_CONTROL, 8'hC0);
    acc(1'b1, OFF_CONTROL, {4'h0, SRC_NVM});
    @(posedge clk_sys_in);
    start <= 1'b1;
    slow <= s;
    @(posedge clk_sys_in);
    start <= 1'b0;
    rd(OFF_RESULT0, 8'h00);
    for (int i = 0; i < 100 && busy_out !== 1'b0; i++)
      @(posedge clk_sys_in);
    rd32(32'hCBF43926);
    $display("test flash done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_narrow;
    t_wide;
    t_flash(1'b1);
    t_flash(1'b0);
    wrap_up;
  end
endmodule
`default_nettype wire
